// ==== bcacs_bank.sv ====
// Alarm level and converter state registers with event flags.
// Assumes a one-cycle read/write strobe port decoded by the serial
// management interface, and analog conditions synchronous to clk.
//
// Contract
// (R01) Alarm interrupt at threshold unless disabled
// (R02) Threshold equals field times 50mA minus 50mA
// (R03) All-zero field means zero amps
// (R04) Alarm resets to 0x50, disable clear
// (R05) Thermal event flag sets, interrupts, read-clears
// (R06) Thermal live bit follows condition
// (R07) Bit 5 shows bus voltage too low
// (R08) Bit 4 shows bus voltage too high
// (R09) Soft-start timeout stops switching, flags, interrupts
// (R10) Switching start starts timer and interrupts
// (R11) Host ramps current before timeout
// (R12) Start interrupt unmaskable, once per start
// (R13) Bit 2 shows converter switching
// (R14) FET limit flag sets, interrupts, read-clears
// (R15) Pin check failure flags when charging
// (R16) Register reset restores alarm defaults
// (R17) Reset command restores, reads zero
// (R18) Read captures before clear, keeps events
// (R19) State register ignores writes, resets zero
module bcacs_bank
    import bcacs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regResetCmd,
    input wire logic [12:0] busCurrentMa,
    input wire bcacs_cond_t cond,
    input wire logic charge_go,
    input wire logic [1:0] ssTimeSel,
    output logic [7:0] regRdata_r,
    output logic intPulse_r,
    output logic switchEnable_r,
    output logic [12:0] alarmThresholdMa_r
);
    typedef enum {SW_IDLE, SW_RAMP, SW_RUN, SW_HALT} bcacs_sw_t;

    logic [7:0] alarm_r;
    logic [7:0] state_r;
    logic [7:0] state_nxt;
    logic [12:0] threshold;
    logic [11:0] ssCnt_r;
    logic [11:0] ssLimit;
    logic alarmHit_r;
    logic thermalPrev_r;
    logic fetPrev_r;
    logic pinPrev_r;
    logic ssTimeout;
    logic startEvent;
    logic readState;
    logic regReset;
    bcacs_sw_t sw_r;

    function automatic logic [11:0] ss_cycles(input logic [1:0] sel);
        case (sel)
            2'd0: ss_cycles = SS_CYC0;
            2'd1: ss_cycles = SS_CYC1;
            2'd2: ss_cycles = SS_CYC2;
            default: ss_cycles = SS_CYC3;
        endcase
    endfunction

    assign ssLimit = ss_cycles(ssTimeSel);
    // (R17) reset command restores
    assign regReset = regResetCmd;
    assign readState = regRd && (regAddr == ADDR_STATE);

    // (R02) decode threshold
    // (R03) zero field floor
    always_comb begin
        if (alarm_r[6:0] == 7'h00) begin
            threshold = 13'h0000;
        end else begin
            threshold = 13'(alarm_r[6:0] * ALARM_STEP_MA) - ALARM_OFFSET_MA;
        end
    end

    // (R04) alarm reset value
    // (R16) register reset default
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            alarm_r <= ALARM_RESET;
        end else if (clkEn) begin
            if (regReset) begin
                alarm_r <= ALARM_RESET;
            end else if (regWr && regAddr == ADDR_ALARM) begin
                alarm_r <= regWdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            alarmThresholdMa_r <= 13'h0000;
        end else if (clkEn) begin
            alarmThresholdMa_r <= threshold;
        end
    end

    // Switching sequencer with soft-start timer
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sw_r <= SW_IDLE;
            ssCnt_r <= 12'h000;
        end else if (clkEn) begin
            case (sw_r)
                SW_IDLE: begin
                    ssCnt_r <= 12'h000;
                    // (R10) start soft-start timer
                    if (cond.switchReq && !cond.thermalTrip &&
                        !cond.voltLow && !cond.voltHigh) begin
                        sw_r <= SW_RAMP;
                    end
                end
                SW_RAMP: begin
                    ssCnt_r <= ssCnt_r + 12'h001;
                    // (R09) timeout stops switching
                    if (ssTimeout) begin
                        sw_r <= SW_HALT;
                    end else if (!cond.switchReq) begin
                        sw_r <= SW_IDLE;
                    end else if (cond.rampDone) begin
                        sw_r <= SW_RUN;
                    end
                end
                SW_RUN: begin
                    if (!cond.switchReq || cond.thermalTrip) begin
                        sw_r <= SW_IDLE;
                    end
                end
                // Stay halted until the request is dropped
                SW_HALT: begin
                    if (!cond.switchReq) begin
                        sw_r <= SW_IDLE;
                    end
                end
                default: sw_r <= SW_IDLE;
            endcase
        end
    end

    // (R11) host ramp deadline
    assign ssTimeout = (sw_r == SW_RAMP) && !cond.rampDone &&
                       (ssCnt_r >= ssLimit - 12'h001);
    // (R12) once per start
    assign startEvent = (sw_r == SW_IDLE) && cond.switchReq &&
                        !cond.thermalTrip && !cond.voltLow &&
                        !cond.voltHigh;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            switchEnable_r <= 1'b0;
        end else if (clkEn) begin
            // (R13) switching indication
            switchEnable_r <= startEvent ||
                ((sw_r == SW_RAMP || sw_r == SW_RUN) && cond.switchReq &&
                 !ssTimeout &&
                 !(sw_r == SW_RUN && cond.thermalTrip));
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            thermalPrev_r <= 1'b0;
            fetPrev_r <= 1'b0;
            pinPrev_r <= 1'b0;
        end else if (clkEn) begin
            thermalPrev_r <= cond.thermalTrip;
            fetPrev_r <= cond.fetLimit;
            pinPrev_r <= cond.pinCheckFail && charge_go;
        end
    end

    // Event flags: set wins over read-clear
    always_comb begin
        state_nxt = state_r;
        // (R18) clear after capture
        if (readState) begin
            state_nxt[THERMAL_EVENT_BIT] = 1'b0;
            state_nxt[SS_TIMEOUT_BIT] = 1'b0;
            state_nxt[FET_LIMIT_BIT] = 1'b0;
            state_nxt[PIN_FAULT_BIT] = 1'b0;
        end
        // (R05) thermal event flag
        if (cond.thermalTrip && !thermalPrev_r) begin
            state_nxt[THERMAL_EVENT_BIT] = 1'b1;
        end
        // (R09) soft-start timeout flag
        if (ssTimeout) begin
            state_nxt[SS_TIMEOUT_BIT] = 1'b1;
        end
        // (R14) FET limit flag
        if (cond.fetLimit && !fetPrev_r) begin
            state_nxt[FET_LIMIT_BIT] = 1'b1;
        end
        // (R15) pin check flag
        if (cond.pinCheckFail && charge_go && !pinPrev_r) begin
            state_nxt[PIN_FAULT_BIT] = 1'b1;
        end
        // (R06) thermal live
        state_nxt[THERMAL_LIVE_BIT] = cond.thermalTrip;
        // (R07) voltage low live
        state_nxt[VOLT_LOW_BIT] = cond.voltLow;
        // (R08) voltage high live
        state_nxt[VOLT_HIGH_BIT] = cond.voltHigh;
        state_nxt[ACTIVE_BIT] = switchEnable_r;
    end

    // (R19) no writes, zero reset
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_r <= STATE_RESET;
        end else if (clkEn) begin
            if (regReset) begin
                state_r <= STATE_RESET;
            end else begin
                state_r <= state_nxt;
            end
        end
    end

    // (R18) capture read data
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            regRdata_r <= 8'h00;
        end else if (clkEn && regRd) begin
            case (regAddr)
                ADDR_ALARM: regRdata_r <= alarm_r;
                ADDR_STATE: regRdata_r <= state_r;
                default: regRdata_r <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            alarmHit_r <= 1'b0;
        end else if (clkEn) begin
            alarmHit_r <= !alarm_r[ALARM_OFF_BIT] &&
                          (busCurrentMa >= threshold);
        end
    end

    // Interrupt pulse on any new event
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            intPulse_r <= 1'b0;
        end else if (clkEn) begin
            intPulse_r <=
                // (R01) alarm interrupt
                (!alarm_r[ALARM_OFF_BIT] && busCurrentMa >= threshold &&
                 !alarmHit_r) ||
                (cond.thermalTrip && !thermalPrev_r) || ssTimeout ||
                // (R12) unmaskable start interrupt
                startEvent ||
                (cond.fetLimit && !fetPrev_r) ||
                (cond.pinCheckFail && charge_go && !pinPrev_r);
        end
    end
endmodule

// ==== bcacs_pkg.sv ====
// Package for the bus current alarm and converter status bank.
// Assumes a byte-wide register port in the device clock domain.
package bcacs_pkg;
    localparam logic [7:0] ADDR_ALARM = 8'h09;
    localparam logic [7:0] ADDR_STATE = 8'h0A;
    localparam logic [7:0] ALARM_RESET = 8'h50;
    localparam logic [7:0] STATE_RESET = 8'h00;
    localparam int ALARM_OFF_BIT = 7;
    localparam int THERMAL_EVENT_BIT = 7;
    localparam int THERMAL_LIVE_BIT = 6;
    localparam int VOLT_LOW_BIT = 5;
    localparam int VOLT_HIGH_BIT = 4;
    localparam int SS_TIMEOUT_BIT = 3;
    localparam int ACTIVE_BIT = 2;
    localparam int FET_LIMIT_BIT = 1;
    localparam int PIN_FAULT_BIT = 0;
    // Threshold step and offset in milliamps
    localparam logic [12:0] ALARM_STEP_MA = 13'h0032;
    localparam logic [12:0] ALARM_OFFSET_MA = 13'h0032;
    // Soft-start timeout choices in microseconds, converted to clock cycles (25 MHz)
    localparam int SS_TIME_US0 = 10;
    localparam int SS_TIME_US1 = 20;
    localparam int SS_TIME_US2 = 40;
    localparam int SS_TIME_US3 = 80;
    localparam int CLK_MHZ = 25;
    localparam logic [11:0] SS_CYC0 = 12'(SS_TIME_US0 * CLK_MHZ);
    localparam logic [11:0] SS_CYC1 = 12'(SS_TIME_US1 * CLK_MHZ);
    localparam logic [11:0] SS_CYC2 = 12'(SS_TIME_US2 * CLK_MHZ);
    localparam logic [11:0] SS_CYC3 = 12'(SS_TIME_US3 * CLK_MHZ);

    typedef struct packed {
        logic thermalTrip;
        logic voltLow;
        logic voltHigh;
        logic fetLimit;
        logic pinCheckFail;
        logic switchReq;
        logic rampDone;
    } bcacs_cond_t;
endpackage

// ==== bcacs_bank_monitor.sv ====
// Checker for the alarm level and converter state bank ports.
// Assumes clkEn is held high by its surroundings.
module bcacs_bank_monitor
    import bcacs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regResetCmd,
    input wire logic [12:0] busCurrentMa,
    input wire bcacs_cond_t cond,
    input wire logic charge_go,
    input wire logic [1:0] ssTimeSel,
    input wire logic [7:0] regRdata_r,
    input wire logic intPulse_r,
    input wire logic switchEnable_r,
    input wire logic [12:0] alarmThresholdMa_r
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    function automatic logic [12:0] thr(input logic [7:0] v);
        return v[6:0] == 7'h00 ? 13'h0000 :
            13'(v[6:0]) * 13'h0032 - 13'h0032;
    endfunction
    out_reset_a: assert property ($rose(rst_b) |->
        regRdata_r == 8'h00 && !intPulse_r && !switchEnable_r)
        else $error("outputs not clear after reset");
    thr_decode_a: assert property (regWr && regAddr == ADDR_ALARM
        && !regWdata[ALARM_OFF_BIT] |=> ##1
        alarmThresholdMa_r == thr($past(regWdata, 2)))
        else $error("threshold decode wrong");
    cmd_default_a: assert property (regResetCmd |=> ##1
        alarmThresholdMa_r == 13'h0F6E)
        else $error("threshold not default after command");
    thermal_int_a: assert property ($rose(cond.thermalTrip)
        |=> intPulse_r)
        else $error("no interrupt on thermal event");
    fet_int_a: assert property ($rose(cond.fetLimit) |=> intPulse_r)
        else $error("no interrupt on FET limit");
    pin_int_a: assert property ($rose(cond.pinCheckFail && charge_go)
        |=> intPulse_r)
        else $error("no interrupt on pin check fault");
    start_int_a: assert property ($rose(switchEnable_r)
        |-> ##[0:1] intPulse_r)
        else $error("no interrupt at switching start");
    live_bit_a: assert property (regRd && regAddr == ADDR_STATE
        && cond.thermalTrip && $past(cond.thermalTrip)
        |=> regRdata_r[THERMAL_LIVE_BIT])
        else $error("thermal live bit low");
    cover property ($rose(cond.thermalTrip));
    cover property (regRd && regAddr == ADDR_STATE);
    cover property ($fell(switchEnable_r));
endmodule

bind bcacs_bank bcacs_bank_monitor mon (.clk, .rst_b, .clkEn, .regWr,
    .regRd, .regAddr, .regWdata, .regResetCmd, .busCurrentMa, .cond,
    .charge_go, .ssTimeSel, .regRdata_r, .intPulse_r, .switchEnable_r,
    .alarmThresholdMa_r);

// ==== bcacs_host.sv ====
// Host model: byte reads and writes on the bank strobes.
// Called one ns after a rising edge; returns one ns after one.
module bcacs_host (
    input wire logic clk,
    input wire logic [7:0] rdData,
    output logic regWr,
    output logic regRd,
    output logic [7:0] regAddr,
    output logic [7:0] regWdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 8'hFF;
        regWdata = 8'h00;
    end
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [7:0] d, output logic [7:0] q);
        regWr = w;
        regRd = !w;
        regAddr = a;
        regWdata = d;
        @(posedge clk);
        #1;
        q = rdData;
        regWr = 1'b0;
        regRd = 1'b0;
        // Released lines show garbage, not the old value
        regAddr = ~a;
        regWdata = ~d;
        // Idle edge so a following call never re-raises a strobe at once
        @(posedge clk);
        #1;
    endtask
endmodule

// ==== bcacs_bank_bench.sv ====
// Self-checking bench for the alarm and converter state bank.
// Host model drives the strobes; the bench drives the conditions.
module bcacs_bank_bench
    import bcacs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic regResetCmd = 1'b0;
    logic chargeGo = 1'b0;
    logic [12:0] busCurrentMa = 13'h0000;
    bcacs_cond_t cond = '0;
    logic [7:0] rdData, q, regAddr, regWdata;
    logic regWr, regRd, intPulse, swEn;
    logic [12:0] thrMa;
    int num_errors = 0;
    int cmp_count = 0;
    int pulses = 0;
    int p;
    logic [7:0] fv[4] = '{8'h00, 8'h01, 8'h02, 8'h7F};
    logic [12:0] ev[4] = '{13'h0000, 13'h0000, 13'h0032, 13'h189C};
    bcacs_host host (.clk(clk), .rdData(rdData), .regWr(regWr),
        .regRd(regRd), .regAddr(regAddr), .regWdata(regWdata));
    bcacs_bank dut (.clk(clk), .rst_b(rst_b), .clkEn(1'b1),
        .regWr(regWr), .regRd(regRd), .regAddr(regAddr),
        .regWdata(regWdata), .regResetCmd(regResetCmd),
        .busCurrentMa(busCurrentMa), .cond(cond), .charge_go(chargeGo),
        .ssTimeSel(2'h0), .regRdata_r(rdData), .intPulse_r(intPulse),
        .switchEnable_r(swEn), .alarmThresholdMa_r(thrMa));
    initial forever #20 clk = ~clk;
    always @(posedge clk) if (intPulse === 1'b1) pulses++;
    task automatic chk(input logic [12:0] got, input logic [12:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        host.xfer(1'b0, a, 8'h00, q);
        chk(13'(q), 13'(exp));
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.xfer(1'b1, a, d, q);
    endtask
    task automatic t_regs;
        rdchk(ADDR_ALARM, ALARM_RESET);
        rdchk(ADDR_STATE, STATE_RESET);
        wr(ADDR_STATE, 8'hFF);
        rdchk(ADDR_STATE, STATE_RESET);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_ALARM, fv[i]);
            cyc(1);
            chk(thrMa, ev[i]);
        end
        rdchk(ADDR_ALARM, 8'h7F);
    endtask
    task automatic t_alarm;
        wr(ADDR_ALARM, 8'h02);
        cyc(2);
        p = pulses;
        busCurrentMa = 13'h0064;
        cyc(3);
        chk(13'(pulses - p), 13'h0001);
        busCurrentMa = 13'h0000;
        wr(ADDR_ALARM, 8'h82);
        cyc(2);
        busCurrentMa = 13'h0064;
        cyc(3);
        chk(13'(pulses - p), 13'h0001);
        busCurrentMa = 13'h0000;
        regResetCmd = 1'b1;
        cyc(1);
        regResetCmd = 1'b0;
        rdchk(ADDR_ALARM, ALARM_RESET);
    endtask
    task automatic t_events;
        p = pulses;
        cond.thermalTrip = 1'b1;
        cyc(3);
        chk(13'(pulses - p), 13'h0001);
        rdchk(ADDR_STATE, 8'hC0);
        rdchk(ADDR_STATE, 8'h40);
        cond.thermalTrip = 1'b0;
        cond.voltLow = 1'b1;
        cyc(2);
        rdchk(ADDR_STATE, 8'h20);
        cond.voltLow = 1'b0;
        cond.voltHigh = 1'b1;
        cyc(2);
        rdchk(ADDR_STATE, 8'h10);
        cond.voltHigh = 1'b0;
        cond.fetLimit = 1'b1;
        cond.pinCheckFail = 1'b1;
        cyc(2);
        rdchk(ADDR_STATE, 8'h02);
        rdchk(ADDR_STATE, 8'h00);
        chargeGo = 1'b1;
        cyc(2);
        rdchk(ADDR_STATE, 8'h01);
        rdchk(ADDR_STATE, 8'h00);
        cond = '0;
    endtask
    task automatic t_switch;
        p = pulses;
        cond.switchReq = 1'b1;
        cyc(3);
        chk(13'(swEn), 13'h0001);
        chk(13'(pulses - p), 13'h0001);
        rdchk(ADDR_STATE, 8'h04);
        cyc(260);
        chk(13'(swEn), 13'h0000);
        rdchk(ADDR_STATE, 8'h08);
        cond.switchReq = 1'b0;
        cyc(2);
        p = pulses;
        cond.switchReq = 1'b1;
        cond.rampDone = 1'b1;
        cyc(300);
        chk(13'(swEn), 13'h0001);
        chk(13'(pulses - p), 13'h0001);
    endtask
    task automatic end_of_test;
        if (num_errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        num_errors++;
        end_of_test();
    end
    initial begin
        cyc(4);
        rst_b = 1'b1;
        t_regs();
        t_alarm();
        t_events();
        t_switch();
        end_of_test();
    end
endmodule
